// ==== pkg/hsc_pkg.sv ====
// hsc_pkg: offsets, field positions, reset values and carriers of the
// host status and control register bank.
// assumes one device clock; the host port decoder lives outside.
package hsc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int VAL_W  = 12;
  localparam int N_CH   = 3;

  // register offsets
  localparam logic [7:0] OFF_SOFT_RESET = 8'h80;
  localparam logic [7:0] OFF_CHECKSUM   = 8'h81;
  localparam logic [7:0] OFF_PART_CODE  = 8'h82;
  localparam logic [7:0] OFF_TEMP       = 8'h83;
  localparam logic [7:0] OFF_CH2_HIGH   = 8'h84;
  localparam logic [7:0] OFF_CH2_GAIN   = 8'h85;
  localparam logic [7:0] OFF_CH2_OFFS   = 8'h86;
  localparam logic [7:0] OFF_CH1_HIGH   = 8'h87;
  localparam logic [7:0] OFF_CH1_GAIN   = 8'h88;
  localparam logic [7:0] OFF_CH1_OFFS   = 8'h89;
  localparam logic [7:0] OFF_CH0_HIGH   = 8'h8a;
  localparam logic [7:0] OFF_CH0_GAIN   = 8'h8b;
  localparam logic [7:0] OFF_CH0_OFFS   = 8'h8c;
  localparam logic [7:0] OFF_ALARM      = 8'h8d;
  localparam logic [7:0] OFF_SPARE_8E   = 8'h8e;
  localparam logic [7:0] OFF_CTRL       = 8'h90;
  localparam logic [7:0] OFF_SPARE_91   = 8'h91;

  // field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int ALARM_LSB      = 5;
  localparam int LOCK_BIT       = 4;
  localparam int STROBE_BIT     = 1;
  localparam int CLEAR_BIT      = 0;
  localparam int REV_LSB        = 4;

  // reset values and codes
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RST_SPARE    = 8'h00;
  localparam logic [2:0] RST_ALARM    = 3'h0;
  localparam logic [3:0] DOWNLOAD_COMPLETE_CODE_CODE = 4'ha;

  typedef struct packed {
    logic [VAL_W-1:0] gain;
    logic [VAL_W-1:0] offset;
  } chan_val_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] wdata;
  } host_req_s;

endpackage

// ==== src/readback_snapshot.sv ====
// readback_snapshot: holds one channel's gain and offset as last strobed.
// assumes snap is a one-cycle pulse and clear is the bank's soft reset.
`timescale 1ns/1ps
module readback_snapshot
  import hsc_pkg::*;
#(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      clear,
  // capture
  input  wire logic      snap,
  input  wire chan_val_s live,
  output chan_val_s      held
);

  initial begin
    if (W != VAL_W) $error("readback_snapshot: W must match VAL_W");
  end

  chan_val_s s;
  chan_val_s next_s;

  always_comb begin
    next_s = s;
    // strobe freezes the live value so both halves read coherently
    if (snap) begin
      next_s = live;
    end
    if (clear) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign held = s;

endmodule

// ==== src/host_status_control_regs.sv ====
// host_status_control_regs: upper register bank reached only by the host.
// assumes a decoded register port: one request per cycle, read or write.
`timescale 1ns/1ps
module host_status_control_regs
  import hsc_pkg::*;
#(
  parameter int         CHANNELS  = 3,
  parameter logic [3:0] REV_CODE  = 4'h3,  // arbitrary value
  parameter logic [3:0] PART_CODE = 4'h9   // arbitrary value
) (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // host register port
  input  wire host_req_s            REG_REQ,
  output logic [DATA_W-1:0]         REG_RDATA,
  output logic                      REG_RVALID,
  // device state
  input  wire chan_val_s [N_CH-1:0] CHAN_LIVE,
  input  wire logic [N_CH-1:0]      CH_FAULT,
  input  wire logic [DATA_W-1:0]    TEMP_CODE,
  input  wire logic [DATA_W-1:0]    CFG_CHECKSUM,
  input  wire logic [3:0]           DL_CODE,
  // status out
  output logic                      SOFT_RESET,
  output logic                      DOWNLOAD_DONE,
  output logic [N_CH-1:0]           CH_FAULT_FLAGS
);

  initial begin
    if (CHANNELS != N_CH) $error("host_status_control_regs: CHANNELS must be 3");
  end

  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic [N_CH-1:0]   alarm;
    logic [DATA_W-1:0] spare_8e;
    logic [DATA_W-1:0] spare_91;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              srst;
    logic              download_complete_code;
  } bank_s;

  localparam bank_s BANK_RST = '{ctrl: RST_CTRL, alarm: RST_ALARM, spare_8e: RST_SPARE,
                                 spare_91: RST_SPARE, rdata: '0, rvalid: 1'b0,
                                 srst: 1'b0, download_complete_code: 1'b0};

  bank_s s;
  bank_s next_s;

  chan_val_s [N_CH-1:0] held;
  logic                 snap;
  logic                 allowed;
  logic                 wr_ok;
  logic                 rd_ok;
  logic [DATA_W-1:0]    rd_mux;

  // one snapshot per output channel
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_snap
      readback_snapshot #(
        .W (VAL_W)
      ) u_snap (
        .clk   (CLK),
        .rst_n (RST_N),
        .clear (s.srst),
        .snap  (snap),
        .live  (CHAN_LIVE[g]),
        .held  (held[g])
      );
    end
  endgenerate

  // the control register stays reachable so a locked bank can be unlocked
  assign allowed = !s.ctrl[LOCK_BIT] || (REG_REQ.addr == OFF_CTRL);
  assign wr_ok   = REG_REQ.wr && allowed && !s.srst;
  assign rd_ok   = REG_REQ.rd && allowed;
  assign snap    = wr_ok && (REG_REQ.addr == OFF_CTRL) && REG_REQ.wdata[STROBE_BIT];

  always_comb begin
    rd_mux = '0;
    unique case (REG_REQ.addr)
      OFF_SOFT_RESET: rd_mux = {s.srst, 7'h00};
      OFF_CHECKSUM:   rd_mux = CFG_CHECKSUM;
      OFF_PART_CODE:  rd_mux = {REV_CODE, PART_CODE};
      OFF_TEMP:       rd_mux = TEMP_CODE;
      OFF_CH2_HIGH:   rd_mux = {held[2].gain[11:8], held[2].offset[11:8]};
      OFF_CH2_GAIN:   rd_mux = held[2].gain[7:0];
      OFF_CH2_OFFS:   rd_mux = held[2].offset[7:0];
      OFF_CH1_HIGH:   rd_mux = {held[1].gain[11:8], held[1].offset[11:8]};
      OFF_CH1_GAIN:   rd_mux = held[1].gain[7:0];
      OFF_CH1_OFFS:   rd_mux = held[1].offset[7:0];
      OFF_CH0_HIGH:   rd_mux = {held[0].gain[11:8], held[0].offset[11:8]};
      OFF_CH0_GAIN:   rd_mux = held[0].gain[7:0];
      OFF_CH0_OFFS:   rd_mux = held[0].offset[7:0];
      OFF_ALARM:      rd_mux = {s.alarm, 5'h00};
      OFF_SPARE_8E:   rd_mux = s.spare_8e;
      OFF_CTRL:       rd_mux = s.ctrl;
      OFF_SPARE_91:   rd_mux = s.spare_91;
      default:        rd_mux = '0;
    endcase
  end

  always_comb begin
    next_s        = s;
    next_s.rvalid = REG_REQ.rd;
    // a locked read still answers, with zero, so the host never hangs
    next_s.rdata  = rd_ok ? rd_mux : '0;
    if (wr_ok) begin
      unique case (REG_REQ.addr)
        OFF_SOFT_RESET: next_s.srst = 1'b1;
        OFF_ALARM:      next_s.alarm = REG_REQ.wdata[ALARM_LSB +: N_CH];
        OFF_SPARE_8E:   next_s.spare_8e = REG_REQ.wdata;
        OFF_SPARE_91:   next_s.spare_91 = REG_REQ.wdata;
        OFF_CTRL:       next_s.ctrl = REG_REQ.wdata;
        default:        next_s.ctrl = s.ctrl;
      endcase
      if ((REG_REQ.addr == OFF_CTRL) && REG_REQ.wdata[CLEAR_BIT]) begin
        next_s.alarm = '0;
      end
    end
    // a fault in the clearing cycle is kept: set wins over clear
    next_s.alarm   = next_s.alarm | CH_FAULT;
    next_s.download_complete_code = (DL_CODE == DOWNLOAD_COMPLETE_CODE_CODE);
    if (s.srst) begin
      next_s        = BANK_RST;
      // a read in the pulse cycle still answers, so a host awaiting it never stalls
      next_s.rvalid = REG_REQ.rd;
      next_s.rdata  = rd_ok ? rd_mux : '0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= BANK_RST;
    end else begin
      s <= next_s;
    end
  end

  assign REG_RDATA      = s.rdata;
  assign REG_RVALID     = s.rvalid;
  assign SOFT_RESET     = s.srst;
  assign DOWNLOAD_DONE  = s.download_complete_code;
  assign CH_FAULT_FLAGS = s.alarm;

  // helpers read only by the checks
  logic [DATA_W-1:0]    ch2_high;
  logic [DATA_W-1:0]    ch2_gain_lo;
  logic                 locked;
  chan_val_s [N_CH-1:0] live_q;

  assign ch2_high    = {held[2].gain[11:8], held[2].offset[11:8]};
  assign ch2_gain_lo = held[2].gain[7:0];
  assign locked      = s.ctrl[LOCK_BIT];
  assign live_q      = CHAN_LIVE;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence seq_open_wr(logic [7:0] off);
    REG_REQ.wr && !locked && !s.srst && (REG_REQ.addr == off);
  endsequence

  sequence seq_open_rd(logic [7:0] off);
    REG_REQ.rd && !REG_REQ.wr && !locked && !s.srst && (REG_REQ.addr == off);
  endsequence

  sequence seq_locked_wr;
    REG_REQ.wr && locked && !s.srst && (REG_REQ.addr != OFF_CTRL);
  endsequence

  chk_srst_cycle: assert property (
    seq_open_wr(OFF_SOFT_RESET) |=> SOFT_RESET ##1 (!SOFT_RESET && s.ctrl == RST_CTRL
      && s.spare_8e == RST_SPARE && held[2] == '0))
    else $error("soft reset did not pulse once and restore defaults");

  chk_ch2_high_read: assert property (
    seq_open_rd(OFF_CH2_HIGH) |=> REG_RVALID && REG_RDATA == $past(ch2_high))
    else $error("channel 2 high nibbles read back wrong");

  chk_ch2_gain_low: assert property (
    seq_open_rd(OFF_CH2_GAIN) |=> REG_RVALID && REG_RDATA == $past(ch2_gain_lo))
    else $error("channel 2 gain low byte read back wrong");

  chk_lock_write_ignored: assert property (
    seq_locked_wr |=> $stable(s.spare_8e) && $stable(s.spare_91) && !SOFT_RESET)
    else $error("write accepted while bank locked");

  chk_lock_read_zero: assert property (
    REG_REQ.rd && locked && REG_REQ.addr != OFF_CTRL |=> REG_RVALID && REG_RDATA == '0)
    else $error("read returned data while bank locked");

  chk_open_write_taken: assert property (
    seq_open_wr(OFF_SPARE_8E) |=> s.spare_8e == $past(REG_REQ.wdata))
    else $error("unlocked write not stored");

  chk_strobe_capture: assert property (
    snap |=> held == $past(live_q))
    else $error("strobe did not capture live gain and offset");

  chk_alarm_clear: assert property (
    seq_open_wr(OFF_CTRL) ##0 REG_REQ.wdata[CLEAR_BIT] && CH_FAULT == '0
      |=> CH_FAULT_FLAGS == '0)
    else $error("alarm clear left a flag set");

  chk_alarm_sticky: assert property (
    !s.srst && CH_FAULT != '0 |=> (CH_FAULT_FLAGS & $past(CH_FAULT)) == $past(CH_FAULT))
    else $error("fault did not set its alarm flag");

  chk_alarm_hold: assert property (
    !s.srst && CH_FAULT == '0 && !wr_ok |=> CH_FAULT_FLAGS == $past(CH_FAULT_FLAGS))
    else $error("alarm flag changed without fault or host clear");

  chk_download_code: assert property (
    !s.srst |=> DOWNLOAD_DONE == ($past(DL_CODE) == DOWNLOAD_COMPLETE_CODE_CODE))
    else $error("download complete does not match code 1010b");

  // soft reset pulse, answers and access paths
  chk_srst_read_answer: assert property (
    REG_REQ.rd && s.srst && REG_REQ.addr == OFF_SOFT_RESET |=> REG_RVALID && REG_RDATA == 8'h80)
    else $error("read in soft reset cycle not answered");

  chk_srst_defaults: assert property (
    s.srst |=> CH_FAULT_FLAGS == '0 && !DOWNLOAD_DONE && held == '0
      && s.spare_91 == RST_SPARE)
    else $error("soft reset left state away from defaults");

  chk_idle_no_answer: assert property (
    !REG_REQ.rd |=> !REG_RVALID && REG_RDATA == '0)
    else $error("answer given without a read");

  chk_ctrl_write_locked: assert property (
    REG_REQ.wr && locked && !s.srst && REG_REQ.addr == OFF_CTRL
      |=> s.ctrl == $past(REG_REQ.wdata))
    else $error("control register not writable while locked");

  chk_ctrl_read_locked: assert property (
    REG_REQ.rd && locked && REG_REQ.addr == OFF_CTRL |=> REG_RDATA == $past(s.ctrl))
    else $error("control register not readable while locked");

  chk_alarm_write: assert property (
    seq_open_wr(OFF_ALARM) ##0 CH_FAULT == '0
      |=> CH_FAULT_FLAGS == $past(REG_REQ.wdata[ALARM_LSB +: N_CH]))
    else $error("alarm flags not loaded by host write");

  chk_spare_91_write: assert property (
    seq_open_wr(OFF_SPARE_91) |=> s.spare_91 == $past(REG_REQ.wdata))
    else $error("unlocked write to spare register not stored");

  chk_ro_write_ignored: assert property (
    seq_open_wr(OFF_TEMP) |=> $stable(s.ctrl) && $stable(s.spare_8e) && $stable(s.spare_91))
    else $error("write to read-only register changed storage");

  chk_temp_read: assert property (
    seq_open_rd(OFF_TEMP) |=> REG_RVALID && REG_RDATA == $past(TEMP_CODE))
    else $error("temperature read back wrong");

  chk_checksum_read: assert property (
    seq_open_rd(OFF_CHECKSUM) |=> REG_RVALID && REG_RDATA == $past(CFG_CHECKSUM))
    else $error("checksum read back wrong");

  chk_part_code_read: assert property (
    seq_open_rd(OFF_PART_CODE) |=> REG_RVALID && REG_RDATA == {REV_CODE, PART_CODE})
    else $error("revision and part code read back wrong");

  chk_alarm_read: assert property (
    seq_open_rd(OFF_ALARM) |=> REG_RVALID && REG_RDATA == {$past(s.alarm), 5'h00})
    else $error("alarm flags read back wrong");

  chk_ch2_offs_low: assert property (
    seq_open_rd(OFF_CH2_OFFS) |=> REG_RVALID && REG_RDATA == $past(held[2].offset[7:0]))
    else $error("channel 2 offset low byte read back wrong");

  chk_ch1_high_read: assert property (
    seq_open_rd(OFF_CH1_HIGH) |=> REG_RDATA == $past({held[1].gain[11:8], held[1].offset[11:8]}))
    else $error("channel 1 high nibbles read back wrong");

  chk_ch1_gain_low: assert property (
    seq_open_rd(OFF_CH1_GAIN) |=> REG_RVALID && REG_RDATA == $past(held[1].gain[7:0]))
    else $error("channel 1 gain low byte read back wrong");

  chk_ch0_high_read: assert property (
    seq_open_rd(OFF_CH0_HIGH) |=> REG_RDATA == $past({held[0].gain[11:8], held[0].offset[11:8]}))
    else $error("channel 0 high nibbles read back wrong");

  chk_snapshot_hold: assert property (
    !snap && !s.srst |=> $stable(held))
    else $error("readback changed without a strobe");

endmodule

// ==== verif/host_mcu_model.sv ====
// host_mcu_model: external controller issuing register reads and writes.
// assumes the bank takes one access per cycle and answers reads a cycle later.
`timescale 1ns/1ps
module host_mcu_model
  import hsc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // register port
  output host_req_s              req,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rvalid
);
  initial req = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};

  // released lines flip so that a stale address never reads as a match
  task automatic release_bus();
    req.wr = 1'b0;
    req.rd = 1'b0;
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1 req = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(posedge clk);
    #1 release_bus();
  endtask

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    @(posedge clk);
    #1 req = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: ~req.wdata};
    @(posedge clk);
    #1 release_bus();
    data = rdata;
    valid = rvalid;
  endtask

  // back-to-back write then read with no idle cycle between, as the port allows
  task automatic write_read(input logic [7:0] waddr, input logic [7:0] wdata,
                            input logic [7:0] raddr, output logic [7:0] data,
                            output logic valid);
    @(posedge clk);
    #1 req = '{addr: waddr, wr: 1'b1, rd: 1'b0, wdata: wdata};
    @(posedge clk);
    #1 req = '{addr: raddr, wr: 1'b0, rd: 1'b1, wdata: ~wdata};
    @(posedge clk);
    #1 release_bus();
    data = rdata;
    valid = rvalid;
  endtask

  // readbacks are stale until captured, so strobe before reading them
  task automatic strobe();
    reg_write(OFF_CTRL, 8'h01 << STROBE_BIT);
  endtask
endmodule

// ==== verif/host_status_control_regs_tb.sv ====
// host_status_control_regs_tb: register-level tests of the host bank.
// assumes host_mcu_model drives the port; live inputs set by this bench.
`timescale 1ns/1ps
module host_status_control_regs_tb;
  import hsc_pkg::*;
  localparam logic [3:0] REV  = 4'h3;  // arbitrary value
  localparam logic [3:0] PART = 4'h9;  // arbitrary value
  logic                 clk;
  logic                 rst_n;
  host_req_s            req;
  logic [7:0]           rdata;
  logic                 rvalid;
  chan_val_s [N_CH-1:0] live;
  logic [N_CH-1:0]      fault;
  logic [7:0]           temp_code;
  logic [7:0]           cfg_sum;
  logic [3:0]           dl_code;
  logic                 soft_reset;
  logic                 download_complete_code;
  logic [N_CH-1:0]      flags;
  logic [7:0]           exp_rb [9];
  logic [7:0]           rd_byte;
  logic                 rd_seen;
  int                   fails;
  int                   samples_checked;

  host_status_control_regs #(.CHANNELS(3), .REV_CODE(REV), .PART_CODE(PART)) dut_u (
    .CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .CHAN_LIVE(live), .CH_FAULT(fault), .TEMP_CODE(temp_code), .CFG_CHECKSUM(cfg_sum),
    .DL_CODE(dl_code), .SOFT_RESET(soft_reset), .DOWNLOAD_DONE(download_complete_code),
    .CH_FAULT_FLAGS(flags));

  host_mcu_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  task automatic check_byte(input logic [7:0] exp, input logic [7:0] act, input string what);
    samples_checked++;
    if (act !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s exp %h got %h", $time, what, exp, act);
    end
  endtask

  task automatic check_flag(input logic exp, input logic act, input string what);
    samples_checked++;
    if (act !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s exp %b got %b", $time, what, exp, act);
    end
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    host_u.reg_read(addr, d, v);
    check_flag(1'b1, v, "read answer");
    check_byte(exp, d, "read data");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is about a hundred cycles
  initial begin
    #20000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    fault = 3'b000;
    temp_code = 8'h47;
    cfg_sum = 8'h3c;
    dl_code = 4'h5;
    live[2] = '{gain: 12'habc, offset: 12'h5de};
    live[1] = '{gain: 12'h123, offset: 12'h456};
    live[0] = '{gain: 12'h9f0, offset: 12'he0f};
    exp_rb = '{8'ha5, 8'hbc, 8'hde, 8'h14, 8'h23, 8'h56, 8'h9e, 8'hf0, 8'h0f};
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    read_check(OFF_SOFT_RESET, 8'h00);
    read_check(OFF_CHECKSUM, cfg_sum);
    read_check(OFF_PART_CODE, {REV, PART});
    read_check(OFF_TEMP, temp_code);
    for (int i = 0; i < 9; i++) read_check(OFF_CH2_HIGH + 8'(i), 8'h00);
    read_check(OFF_ALARM, 8'h00);
    read_check(8'h8f, 8'h00);
    $display("test reset_values done");
    host_u.strobe();
    for (int i = 0; i < 9; i++) read_check(OFF_CH2_HIGH + 8'(i), exp_rb[i]);
    $display("test snapshot done");
    @(posedge clk);
    #1 fault = 3'b010;
    @(posedge clk);
    #1 fault = 3'b000;
    check_byte(8'h02, 8'(flags), "fault flags set");
    read_check(OFF_ALARM, 8'h40);
    host_u.reg_write(OFF_CTRL, 8'h00);
    check_byte(8'h02, 8'(flags), "flags kept");
    host_u.reg_write(OFF_CTRL, 8'h01 << CLEAR_BIT);
    check_byte(8'h00, 8'(flags), "flags cleared");
    host_u.reg_write(OFF_ALARM, 8'ha0);
    check_byte(8'h05, 8'(flags), "flags written");
    host_u.reg_write(OFF_CTRL, 8'h01 << CLEAR_BIT);
    check_byte(8'h00, 8'(flags), "written flags cleared");
    $display("test alarms done");
    host_u.reg_write(OFF_TEMP, 8'hff);
    read_check(OFF_TEMP, temp_code);
    host_u.reg_write(OFF_SPARE_8E, 8'h5a);
    host_u.reg_write(OFF_CTRL, 8'h01 << LOCK_BIT);
    read_check(OFF_SPARE_8E, 8'h00);
    host_u.reg_write(OFF_SPARE_8E, 8'ha5);
    read_check(OFF_CTRL, 8'h10);
    host_u.reg_write(OFF_CTRL, 8'h00);
    read_check(OFF_SPARE_8E, 8'h5a);
    $display("test lock done");
    @(posedge clk);
    #1 dl_code = DOWNLOAD_COMPLETE_CODE_CODE;
    @(posedge clk);
    #1 check_flag(1'b1, download_complete_code, "download done");
    dl_code = 4'hb;
    @(posedge clk);
    #1 check_flag(1'b0, download_complete_code, "download pending");
    $display("test download done");
    host_u.reg_write(OFF_SPARE_91, 8'h77);
    host_u.reg_write(OFF_SOFT_RESET, 8'h80);
    check_flag(1'b1, soft_reset, "soft reset pulse");
    @(posedge clk);
    #1 check_flag(1'b0, soft_reset, "soft reset clears");
    read_check(OFF_SPARE_91, 8'h00);
    read_check(OFF_CH2_GAIN, 8'h00);
    host_u.write_read(OFF_SOFT_RESET, 8'h80, OFF_SOFT_RESET, rd_byte, rd_seen);
    check_flag(1'b1, rd_seen, "read during reset pulse");
    check_byte(8'h80, rd_byte, "reset bit during pulse");
    $display("test soft_reset done");
    wrap_up();
  end
endmodule
